//--- rtl/srt_pkg.sv
// Purpose: Shared constants and types of the serial port.
// Assumes: 200 MHz system clock, APB register access.
// Notes:   Register offsets are byte addresses.
package srt_pkg;
  // ----------------------------------------------------------
  // Timing
  // ----------------------------------------------------------
  localparam int CLK_NS = 5;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_NS;
  localparam int CLK_HZ = 1000000000 / CLK_NS;
  localparam int BPS_MIN = 50;
  localparam int BPS_MAX = 921600;
  localparam logic [21:0] DIV_MIN = 22'(CLK_HZ / BPS_MAX);
  localparam logic [21:0] DIV_MAX = 22'(CLK_HZ / BPS_MIN);
  localparam logic [6:0] DLY_MAX_MS = 7'h64;
  localparam logic [15:0] ICT_AUTO = 16'h000F;
  localparam logic [15:0] IFD_AUTO = 16'h0023;
  // ----------------------------------------------------------
  // Register map
  // ----------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_BAUD = 8'h04;
  localparam logic [7:0] ADR_DLY = 8'h08;
  localparam logic [7:0] ADR_RTU = 8'h0C;
  localparam logic [7:0] ADR_RSPTO = 8'h10;
  localparam logic [7:0] ADR_TXD = 8'h14;
  localparam logic [7:0] ADR_RXD = 8'h18;
  localparam logic [7:0] ADR_STAT = 8'h1C;
  localparam logic [31:0] CTRL_RST = 32'h0000_0040;
  localparam logic [21:0] BAUD_RST = 22'h0006C8;
  localparam int CTRL_PAR = 0;
  localparam int CTRL_STOP2 = 3;
  localparam int CTRL_FLOW = 4;
  localparam int CTRL_FIFO = 6;
  localparam int CTRL_IF = 7;
  localparam int CTRL_RTU = 9;
  localparam int CTRL_RTSSW = 10;
  localparam int DLY_OFF = 8;
  localparam int RTU_IFD = 16;
  localparam int TXD_LAST = 8;
  localparam int ST_STK = 4;
  localparam int STK_PERR = 0;
  localparam int STK_FERR = 1;
  localparam int STK_OVR = 2;
  localparam int STK_DISC = 3;
  localparam int STK_RSPTO = 4;
  // ----------------------------------------------------------
  // Types
  // ----------------------------------------------------------
  typedef enum logic [2:0] {PAR_NONE = 3'h0, PAR_ODD = 3'h1,
    PAR_EVEN = 3'h2, PAR_MARK = 3'h3, PAR_SPACE = 3'h4} srt_par_t;
  typedef enum logic [1:0] {FLOW_NONE = 2'h0, FLOW_HW = 2'h1,
    FLOW_TOGGLE = 2'h2, FLOW_RSVD = 2'h3} srt_flow_t;
  typedef enum logic [1:0] {IF_SE = 2'h0, IF_FD4 = 2'h1,
    IF_MD2 = 2'h2, IF_MD4 = 2'h3} srt_if_t;
  typedef enum logic [1:0] {TX_IDLE = 2'h0, TX_LEAD = 2'h1,
    TX_SHIFT = 2'h2, TX_TAIL = 2'h3} srt_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE = 3'h0, RX_START = 3'h1,
    RX_DATA = 3'h2, RX_PAR = 3'h3, RX_STOP = 3'h4} srt_rx_st_t;

  function automatic logic par_bit(input srt_par_t m,
                                   input logic [7:0] d);
    case (m)
      PAR_ODD: return ~^d;
      PAR_EVEN: return ^d;
      PAR_MARK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [6:0] clamp_ms(input logic [7:0] v);
    return (v > {1'b0, DLY_MAX_MS}) ? DLY_MAX_MS : v[6:0];
  endfunction
endpackage

//--- rtl/srt_fifo.sv
// Purpose: Receive character memory with registered read data.
// Assumes: Flush and push in one cycle keep only the pushed word.
// Notes:   Read data shows the oldest word whenever not empty.
`timescale 1ns/1ps
module srt_fifo #(
  parameter int W = 8,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Control
  input wire logic push,
  input wire logic [W-1:0] wdata,
  input wire logic pop,
  input wire logic flush,
  // State
  output logic [W-1:0] rdata,
  output logic [AW:0] count,
  output logic full,
  output logic empty
);
  localparam int DEPTH = 1 << AW;
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic [W-1:0] rd_r, rd_nxt;
  logic do_push, do_pop;

  if (AW < 1) begin : g_chk
    $error("srt_fifo: AW must be at least 1");
  end

  assign full = cnt_r == (AW + 1)'(DEPTH);
  assign empty = cnt_r == '0;
  assign count = cnt_r;
  assign rdata = rd_r;
  assign do_pop = pop && !empty && !flush;
  assign do_push = push && (!full || flush);

  always_comb begin
    wp_nxt = flush ? '0 : wp_r;
    rp_nxt = flush ? '0 : rp_r;
    cnt_nxt = flush ? '0 : cnt_r;
    if (do_push) begin
      wp_nxt = wp_nxt + 1'b1;
      cnt_nxt = cnt_nxt + 1'b1;
    end
    if (do_pop) begin
      rp_nxt = rp_r + 1'b1;
      cnt_nxt = cnt_nxt - 1'b1;
    end
    rd_nxt = mem[rp_nxt];
    if (do_push && (flush ? '0 : wp_r) == rp_nxt) begin
      rd_nxt = wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      mem[flush ? '0 : wp_r] <= wdata;
    end
    if (srst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      rd_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      rd_r <= rd_nxt;
    end
  end
endmodule // srt_fifo

//--- rtl/srt_rx.sv
// Purpose: Character receiver sampling each bit at its centre.
// Assumes: Rxd is synchronous to clk_sys.
// Notes:   A start bit gone at its centre is taken as a glitch.
`timescale 1ns/1ps
module srt_rx (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Line and setup
  input wire logic rxd,
  input wire logic rx_en,
  input wire logic [21:0] div,
  input wire srt_pkg::srt_par_t par_m,
  // Received character
  output logic chr_vld,
  output logic [7:0] chr_data,
  output logic par_err,
  output logic frm_err
);
  srt_pkg::srt_rx_st_t st_r, st_nxt;
  logic [21:0] cnt_r, cnt_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic vld_r, vld_nxt, perr_r, perr_nxt, ferr_r, ferr_nxt;
  logic due;

  assign due = cnt_r == '0;
  assign chr_vld = vld_r;
  assign chr_data = sh_r;
  assign par_err = perr_r;
  assign frm_err = ferr_r;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = due ? cnt_r : cnt_r - 22'h1;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    vld_nxt = 1'b0;
    perr_nxt = perr_r;
    ferr_nxt = ferr_r;
    unique case (st_r)
      srt_pkg::RX_IDLE: if (rx_en && !rxd) begin
        st_nxt = srt_pkg::RX_START;
        cnt_nxt = {1'b0, div[21:1]};
      end
      srt_pkg::RX_START: if (due) begin
        st_nxt = rxd ? srt_pkg::RX_IDLE : srt_pkg::RX_DATA;
        cnt_nxt = div - 22'h1;
        bit_nxt = '0;
      end
      srt_pkg::RX_DATA: if (due) begin
        sh_nxt = {rxd, sh_r[7:1]}; // RL15
        cnt_nxt = div - 22'h1;
        bit_nxt = bit_r + 3'h1;
        perr_nxt = 1'b0;
        if (bit_r == 3'h7) begin
          st_nxt = (par_m == srt_pkg::PAR_NONE) ?
                   srt_pkg::RX_STOP : srt_pkg::RX_PAR;
        end
      end
      srt_pkg::RX_PAR: if (due) begin
        perr_nxt = rxd != srt_pkg::par_bit(par_m, sh_r); // RL2
        cnt_nxt = div - 22'h1;
        st_nxt = srt_pkg::RX_STOP;
      end
      srt_pkg::RX_STOP: if (due) begin
        ferr_nxt = !rxd;
        vld_nxt = 1'b1;
        st_nxt = srt_pkg::RX_IDLE;
      end
      default: st_nxt = srt_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= srt_pkg::RX_IDLE;
      cnt_r <= '0;
      bit_r <= '0;
      sh_r <= '0;
      vld_r <= 1'b0;
      perr_r <= 1'b0;
      ferr_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      vld_r <= vld_nxt;
      perr_r <= perr_nxt;
      ferr_r <= ferr_nxt;
    end
  end
endmodule // srt_rx

//--- rtl/srt_uart.sv
// Purpose: Serial port with direction toggle and RTU frame timing.
// Assumes: One clock, synchronous reset, APB register access.
// Notes:
// Notes on behaviour
// RL1: Line rate programmable from 50 to 921600.
// RL2: Parity none, odd, even, mark or space.
// RL3: Interface single-ended, full duplex or multidrop.
// RL4: Toggle mode: RTS off without pending data.
// RL5: Toggle mode: RTS on before, off after.
// RL6: Lead and tail delays 0-100 ms, toggle only.
// RL7: Wait lead delay after RTS before data.
// RL8: Wait tail delay after last character, drop RTS.
// RL9: Toggle mode only on single-ended interface.
// RL10: FIFO can be off for lowest latency.
// RL11: RTU: character gap too long discards frame.
// RL12: Zero inter-character timeout selects automatic value.
// RL13: RTU: hold frame for inter-frame delay; zero automatic.
// RL14: No reply within timeout abandons the request.
// RL15: Eight data bits, LSB first, one/two stops.
`timescale 1ns/1ps
module srt_uart #(
  parameter int CYC_MS = srt_pkg::CYC_PER_MS,
  parameter int FIFO_AW = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial line
  input wire logic rxd,
  input wire logic cts,
  output logic txd,
  output logic rts,
  output logic drv_en
);
  localparam int DCW = $clog2(CYC_MS + 1);
  localparam logic [DCW-1:0] MS_LAST = DCW'(CYC_MS - 1);
  if (CYC_MS < 1 || FIFO_AW < 1) begin : g_chk
    $error("srt_uart: bad parameter");
  end

  // ----------------------------------------------------------
  // Register file
  // ----------------------------------------------------------
  logic [31:0] ctrl_r, ctrl_nxt, prd_r, prd_nxt;
  logic [21:0] div_r, div_nxt;
  logic [6:0] on_r, on_nxt, off_r, off_nxt;
  logic [15:0] ict_r, ict_nxt, ifd_r, ifd_nxt;
  logic [16:0] rsp_r, rsp_nxt;
  logic [4:0] stk_r, stk_nxt, stk_set;
  logic [8:0] hold_r, hold_nxt;
  logic hfull_r, hfull_nxt;
  logic acc_w, acc_r, setup, known, tx_wr, rx_pop, load;
  logic toggle_eff, rx_avail, comm_r, rsp_w_r;
  srt_pkg::srt_par_t par_m;
  srt_pkg::srt_flow_t flow;
  srt_pkg::srt_if_t ifc;
  srt_pkg::srt_tx_st_t st_r, st_nxt;
  logic [7:0] f_rd;
  logic [FIFO_AW:0] f_cnt;
  logic f_full, f_empty;

  assign par_m = srt_pkg::srt_par_t'(ctrl_r[srt_pkg::CTRL_PAR +: 3]);
  assign flow = srt_pkg::srt_flow_t'(ctrl_r[srt_pkg::CTRL_FLOW +: 2]);
  assign ifc = srt_pkg::srt_if_t'(ctrl_r[srt_pkg::CTRL_IF +: 2]); // RL3
  assign toggle_eff = flow == srt_pkg::FLOW_TOGGLE &&
                      ifc == srt_pkg::IF_SE; // RL9
  assign setup = psel && !penable;
  assign acc_w = psel && penable && pwrite;
  assign acc_r = psel && penable && !pwrite;
  assign known = paddr[1:0] == 2'h0 && paddr <= srt_pkg::ADR_STAT;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !known;
  assign prdata = prd_r;
  assign tx_wr = acc_w && paddr == srt_pkg::ADR_TXD && !hfull_r;
  assign rx_pop = acc_r && paddr == srt_pkg::ADR_RXD && rx_avail;

  always_comb begin
    ctrl_nxt = ctrl_r;
    div_nxt = div_r;
    on_nxt = on_r;
    off_nxt = off_r;
    ict_nxt = ict_r;
    ifd_nxt = ifd_r;
    rsp_nxt = rsp_r;
    stk_nxt = stk_r;
    hold_nxt = hold_r;
    hfull_nxt = hfull_r && !load;
    prd_nxt = prd_r;
    if (acc_w) begin
      case (paddr)
        srt_pkg::ADR_CTRL: ctrl_nxt = pwdata;
        srt_pkg::ADR_BAUD: div_nxt = (pwdata < 32'(srt_pkg::DIV_MIN)) ?
          srt_pkg::DIV_MIN : (pwdata > 32'(srt_pkg::DIV_MAX)) ?
          srt_pkg::DIV_MAX : pwdata[21:0]; // RL1
        srt_pkg::ADR_DLY: begin
          on_nxt = srt_pkg::clamp_ms(pwdata[7:0]); // RL6
          off_nxt = srt_pkg::clamp_ms(pwdata[srt_pkg::DLY_OFF +: 8]);
        end
        srt_pkg::ADR_RTU: begin
          ict_nxt = pwdata[15:0];
          ifd_nxt = pwdata[srt_pkg::RTU_IFD +: 16];
        end
        srt_pkg::ADR_RSPTO: rsp_nxt = pwdata[16:0];
        srt_pkg::ADR_STAT: stk_nxt = stk_r & ~pwdata[srt_pkg::ST_STK +: 5];
        default: ;
      endcase
    end
    if (tx_wr) begin
      hold_nxt = pwdata[8:0];
      hfull_nxt = 1'b1;
    end
    stk_nxt = stk_nxt | stk_set;
    if (setup) begin
      case (paddr)
        srt_pkg::ADR_CTRL: prd_nxt = ctrl_r;
        srt_pkg::ADR_BAUD: prd_nxt = {10'h000, div_r};
        srt_pkg::ADR_DLY: prd_nxt = {17'h00000, off_r, 1'b0, on_r};
        srt_pkg::ADR_RTU: prd_nxt = {ifd_r, ict_r};
        srt_pkg::ADR_RSPTO: prd_nxt = {15'h0000, rsp_r};
        srt_pkg::ADR_RXD: prd_nxt = {23'h000000, rx_avail, f_rd};
        srt_pkg::ADR_STAT: prd_nxt = {22'h000000, rsp_w_r, stk_r, rts,
          rx_avail, hfull_r, st_r != srt_pkg::TX_IDLE};
        default: prd_nxt = '0;
      endcase
    end
  end

  // ----------------------------------------------------------
  // Transmitter and direction control
  // ----------------------------------------------------------
  logic [11:0] sh_r, sh_nxt;
  logic [3:0] nb_r, nb_nxt;
  logic [21:0] bc_r, bc_nxt;
  logic [DCW-1:0] dc_r, dc_nxt;
  logic [6:0] dm_r, dm_nxt;
  logic last_r, last_nxt, rts_r, rts_nxt, txd_r, txd_nxt;
  logic de_r, de_nxt, cts_ok, chr_end, tx_fin;
  logic [11:0] frame;
  logic [3:0] nbits;

  assign cts_ok = flow != srt_pkg::FLOW_HW || cts;
  assign frame = (par_m == srt_pkg::PAR_NONE) ? {3'h7, hold_r[7:0], 1'b0}
    : {2'h3, srt_pkg::par_bit(par_m, hold_r[7:0]), hold_r[7:0], 1'b0};
  assign nbits = 4'hA + {3'h0, par_m != srt_pkg::PAR_NONE} +
                 {3'h0, ctrl_r[srt_pkg::CTRL_STOP2]}; // RL15
  assign chr_end = st_r == srt_pkg::TX_SHIFT &&
                   bc_r == div_r - 22'h1 && nb_r == 4'h1;
  assign tx_fin = chr_end && last_r;
  assign txd = txd_r;
  assign rts = rts_r;
  assign drv_en = de_r;

  always_comb begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    nb_nxt = nb_r;
    bc_nxt = bc_r + 22'h1;
    dc_nxt = (dc_r == MS_LAST) ? '0 : dc_r + 1'b1;
    dm_nxt = (dc_r == MS_LAST) ? dm_r + 7'h1 : dm_r;
    last_nxt = last_r;
    load = 1'b0;
    rts_nxt = toggle_eff ? rts_r : (flow == srt_pkg::FLOW_HW) ? !f_full
              : ctrl_r[srt_pkg::CTRL_RTSSW];
    unique case (st_r)
      srt_pkg::TX_IDLE: begin
        if (toggle_eff) rts_nxt = 1'b0; // RL4
        if (hfull_r && cts_ok) begin
          load = 1'b1;
          st_nxt = toggle_eff ? srt_pkg::TX_LEAD : srt_pkg::TX_SHIFT;
          if (toggle_eff) rts_nxt = 1'b1; // RL5
        end
        dc_nxt = '0;
        dm_nxt = '0;
      end
      srt_pkg::TX_LEAD: begin
        bc_nxt = '0;
        if (dm_r >= on_r) st_nxt = srt_pkg::TX_SHIFT; // RL7
      end
      srt_pkg::TX_SHIFT: begin
        if (bc_r == div_r - 22'h1) begin
          bc_nxt = '0;
          sh_nxt = {1'b1, sh_r[11:1]};
          nb_nxt = nb_r - 4'h1;
        end
        if (chr_end) begin
          dc_nxt = '0;
          dm_nxt = '0;
          if (hfull_r && cts_ok) load = 1'b1;
          else st_nxt = toggle_eff ? srt_pkg::TX_TAIL : srt_pkg::TX_IDLE;
        end
      end
      srt_pkg::TX_TAIL: begin
        if (hfull_r && cts_ok) begin
          load = 1'b1;
          st_nxt = srt_pkg::TX_SHIFT;
        end else if (dm_r >= off_r) begin
          st_nxt = srt_pkg::TX_IDLE; // RL8
          rts_nxt = 1'b0;
        end
      end
    endcase
    if (load) begin
      sh_nxt = frame;
      nb_nxt = nbits;
      bc_nxt = '0;
      last_nxt = hold_r[srt_pkg::TXD_LAST];
    end
    txd_nxt = (st_nxt == srt_pkg::TX_SHIFT) ? sh_nxt[0] : 1'b1;
    de_nxt = (ifc == srt_pkg::IF_SE || ifc == srt_pkg::IF_FD4) ||
             st_nxt != srt_pkg::TX_IDLE; // RL3
  end

  // ----------------------------------------------------------
  // Receiver, RTU frame timing and response timeout
  // ----------------------------------------------------------
  logic c_vld, c_perr, c_ferr, rx_en, rx_acc, push, flush;
  logic [7:0] c_dat;
  logic [21:0] bt_r, bt_nxt;
  logic [15:0] gap_r, gap_nxt, ict_eff, ifd_eff;
  logic fopen_r, fopen_nxt, comm_nxt, disc, commit, rsp_to;
  logic rsp_w_nxt;
  logic [DCW-1:0] rc_r, rc_nxt;
  logic [16:0] rm_r, rm_nxt;
  logic rtu_en, fifo_en;

  assign rtu_en = ctrl_r[srt_pkg::CTRL_RTU];
  assign fifo_en = ctrl_r[srt_pkg::CTRL_FIFO];
  assign rx_en = !(ifc == srt_pkg::IF_MD2 && st_r != srt_pkg::TX_IDLE);
  assign ict_eff = (ict_r == '0) ? srt_pkg::ICT_AUTO : ict_r; // RL12
  assign ifd_eff = (ifd_r == '0) ? srt_pkg::IFD_AUTO : ifd_r; // RL13
  assign rx_acc = fifo_en ? !f_full : f_empty; // RL10
  assign disc = rtu_en && c_vld && fopen_r && gap_r > ict_eff; // RL11
  assign commit = rtu_en && fopen_r && gap_r >= ifd_eff; // RL13
  assign rsp_to = rsp_w_r && rm_r >= rsp_r && !c_vld; // RL14
  assign flush = disc || rsp_to;
  assign push = c_vld && (rx_acc || disc);
  assign rx_avail = !f_empty && (!rtu_en || comm_r); // RL13

  srt_rx u_rx (
    .clk_sys(clk_sys),
    .srst(srst),
    .rxd(rxd),
    .rx_en(rx_en),
    .div(div_r),
    .par_m(par_m),
    .chr_vld(c_vld),
    .chr_data(c_dat),
    .par_err(c_perr),
    .frm_err(c_ferr)
  );

  srt_fifo #(.W(8), .AW(FIFO_AW)) u_fifo (
    .clk_sys(clk_sys),
    .srst(srst),
    .push(push),
    .wdata(c_dat),
    .pop(rx_pop),
    .flush(flush),
    .rdata(f_rd),
    .count(f_cnt),
    .full(f_full),
    .empty(f_empty)
  );

  always_comb begin
    bt_nxt = (bt_r >= div_r - 22'h1) ? '0 : bt_r + 22'h1;
    gap_nxt = (bt_r == '0 && gap_r != 16'hFFFF) ? gap_r + 16'h1 : gap_r;
    fopen_nxt = fopen_r && !commit;
    comm_nxt = (comm_r && !f_empty && !flush) || commit;
    if (c_vld) begin
      gap_nxt = '0;
      fopen_nxt = 1'b1;
    end
    stk_set = '0;
    stk_set[srt_pkg::STK_PERR] = c_vld && c_perr;
    stk_set[srt_pkg::STK_FERR] = c_vld && c_ferr;
    stk_set[srt_pkg::STK_OVR] = (c_vld && !rx_acc && !disc) ||
      (acc_w && paddr == srt_pkg::ADR_TXD && hfull_r);
    stk_set[srt_pkg::STK_DISC] = disc;
    stk_set[srt_pkg::STK_RSPTO] = rsp_to;
    rsp_w_nxt = (rsp_w_r && !c_vld && !rsp_to) ||
                (tx_fin && rsp_r != '0); // RL14
    rc_nxt = (rc_r == MS_LAST || tx_fin) ? '0 : rc_r + 1'b1;
    rm_nxt = tx_fin ? '0 : (rc_r == MS_LAST) ? rm_r + 17'h1 : rm_r;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_r <= srt_pkg::CTRL_RST;
      div_r <= srt_pkg::BAUD_RST;
      {on_r, off_r, ict_r, ifd_r, rsp_r} <= '0;
      {stk_r, hold_r, hfull_r, prd_r} <= '0;
      st_r <= srt_pkg::TX_IDLE;
      {sh_r, nb_r, bc_r, dc_r, dm_r, last_r, rts_r} <= '0;
      txd_r <= 1'b1;
      de_r <= 1'b1;
      {bt_r, gap_r, fopen_r, comm_r, rsp_w_r, rc_r, rm_r} <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      div_r <= div_nxt;
      {on_r, off_r, ict_r, ifd_r, rsp_r} <=
        {on_nxt, off_nxt, ict_nxt, ifd_nxt, rsp_nxt};
      {stk_r, hold_r, hfull_r, prd_r} <=
        {stk_nxt, hold_nxt, hfull_nxt, prd_nxt};
      st_r <= st_nxt;
      {sh_r, nb_r, bc_r, dc_r, dm_r, last_r, rts_r} <=
        {sh_nxt, nb_nxt, bc_nxt, dc_nxt, dm_nxt, last_nxt, rts_nxt};
      txd_r <= txd_nxt;
      de_r <= de_nxt;
      {bt_r, gap_r, fopen_r, comm_r, rsp_w_r, rc_r, rm_r} <=
        {bt_nxt, gap_nxt, fopen_nxt, comm_nxt, rsp_w_nxt, rc_nxt, rm_nxt};
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  property p_rts_idle;
    @(posedge clk_sys) disable iff (srst)
    toggle_eff && st_r == srt_pkg::TX_IDLE && !hfull_r |=> !rts_r;
  endproperty
  a_rts_idle: assert property (p_rts_idle) // RL4
    else $error("rts on with nothing to send");
  property p_rts_shift;
    @(posedge clk_sys) disable iff (srst)
    toggle_eff && st_r == srt_pkg::TX_SHIFT |-> rts_r && $past(rts_r);
  endproperty
  a_rts_shift: assert property (p_rts_shift) // RL5
    else $error("rts off while shifting");
  property p_lead;
    @(posedge clk_sys) disable iff (srst)
    toggle_eff && on_r != '0 && $rose(st_r == srt_pkg::TX_SHIFT)
      |-> $past(st_r) == srt_pkg::TX_LEAD && $past(dm_r) >= on_r;
  endproperty
  a_lead: assert property (p_lead) // RL7
    else $error("data started before lead delay");
  property p_tail;
    @(posedge clk_sys) disable iff (srst)
    $fell(rts_r) && toggle_eff |-> $past(st_r) == srt_pkg::TX_TAIL;
  endproperty
  a_tail: assert property (p_tail) // RL8
    else $error("rts dropped without tail delay");
  property p_dly_rng;
    @(posedge clk_sys) disable iff (srst)
    on_r <= srt_pkg::DLY_MAX_MS && off_r <= srt_pkg::DLY_MAX_MS;
  endproperty
  a_dly_rng: assert property (p_dly_rng) // RL6
    else $error("delay above limit");
  property p_div_rng;
    @(posedge clk_sys) disable iff (srst)
    div_r >= srt_pkg::DIV_MIN && div_r <= srt_pkg::DIV_MAX;
  endproperty
  a_div_rng: assert property (p_div_rng) // RL1
    else $error("divisor out of range");
  property p_no_fifo;
    @(posedge clk_sys) disable iff (srst)
    !fifo_en && $stable(ctrl_r) && f_cnt <= 1 |=> f_cnt <= 1;
  endproperty
  a_no_fifo: assert property (p_no_fifo) // RL10
    else $error("more than one character held without fifo");
  property p_disc;
    @(posedge clk_sys) disable iff (srst)
    disc |=> f_cnt == 1 && stk_r[srt_pkg::STK_DISC];
  endproperty
  a_disc: assert property (p_disc) // RL11
    else $error("frame not discarded after long gap");
  property p_hold;
    @(posedge clk_sys) disable iff (srst)
    rtu_en && $rose(rx_avail) |-> $past(commit) || $past(comm_r);
  endproperty
  a_hold: assert property (p_hold) // RL13
    else $error("frame forwarded before inter-frame delay");
  property p_rspto;
    @(posedge clk_sys) disable iff (srst)
    rsp_to |=> !rsp_w_r && f_empty;
  endproperty
  a_rspto: assert property (p_rspto) // RL14
    else $error("request not abandoned on timeout");
endmodule // srt_uart

//--- testbench/srt_slave.sv
// Purpose: Serial slave on the far side of the port.
// Assumes: Eight data bits, one stop bit, even parity on request.
// Notes: The line idles high between characters.
`timescale 1ns/1ps
module srt_slave #(
  parameter int DIV = 217
) (
  // Line
  input wire logic clk_sys,
  input wire logic txd,
  output logic rxd,
  // Received character
  output logic [7:0] got,
  output logic got_stb
);
  initial rxd = 1'b1;
  initial got_stb = 1'b0;
  // Sends start, data LSB first, even parity when par_on, then stop.
  task automatic send(input logic [7:0] b, input logic par_on);
    logic [10:0] f;
    f = {1'b1, ^b, b, 1'b0};
    for (int i = 0; i < (par_on ? 11 : 10); i++) begin
      rxd <= (par_on || i < 9) ? f[i] : 1'b1;
      repeat (DIV) @(posedge clk_sys);
    end
  endtask
  // Samples each bit at its centre, away from the launching edge.
  always @(negedge clk_sys) begin
    if (txd === 1'b0) begin
      repeat (DIV / 2) @(negedge clk_sys);
      for (int i = 0; i < 8; i++) begin
        repeat (DIV) @(negedge clk_sys);
        got[i] <= txd;
      end
      repeat (DIV) @(negedge clk_sys);
      got_stb <= 1'b1;
      @(negedge clk_sys);
      got_stb <= 1'b0;
    end
  end
endmodule // srt_slave

//--- testbench/serial_port_rts_toggle_uart_test.sv
// Purpose: Self-checking bench of the serial port.
// Assumes: 20 cycles per ms, 217 cycles per bit.
// Notes: A slave model sits on the line.
`timescale 1ns/1ps
module serial_port_rts_toggle_uart_test;
  localparam int CMS = 20;
  localparam int DIV = 217;
  logic clk_sys = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, got, b;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, rxd, txd, rts, stb, de;
  integer num_errors = 0, checks_done = 0, n, seed = 32'hcc5e;
  logic [7:0] exp_q[$];
  always #2.5 clk_sys = ~clk_sys;
  srt_uart #(.CYC_MS(CMS), .FIFO_AW(4)) uut (.clk_sys(clk_sys),
    .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .cts(1'b1), .txd(txd), .rts(rts),
    .drv_en(de));
  srt_slave #(.DIV(DIV)) slave (.clk_sys(clk_sys), .txd(txd),
    .rxd(rxd), .got(got), .got_stb(stb));
  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, s);
    checks_done++;
    if (s !== e) begin
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
      num_errors++;
    end
  endtask
  task automatic wt(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    if (s !== v) begin
      num_errors++;
      wrap_up();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    apb(0, 8'h00, 32'h0);
    chk("ctrl", srt_pkg::CTRL_RST, rd);
    apb(0, 8'h04, 32'h0);
    chk("baud", 32'(srt_pkg::BAUD_RST), rd);
    apb(1, 8'h04, 32'h1);
    apb(0, 8'h04, 32'h0);
    chk("bmin", 32'(srt_pkg::DIV_MIN), rd);
    apb(0, 8'h20, 32'h0);
    chk("slverr", 32'h1, 32'(er));
    apb(1, 8'h08, 32'h0000_FF02);
    apb(0, 8'h08, 32'h0);
    chk("dly", 32'h0000_6402, rd);
    apb(1, 8'h00, 32'h0000_0060);
    chk("rts_idle", 32'h0, 32'(rts));
    b = 8'($random(seed));
    exp_q.push_back(b);
    apb(1, 8'h14, {24'h0, b});
    wt(rts, 1'b1, 20);
    wt(txd, 1'b0, 100);
    chk("lead", 32'h1, 32'(n >= 2 * CMS - 2 && n <= 2 * CMS + 3));
    wt(stb, 1'b1, 20 * DIV);
    chk("tx", 32'(exp_q.pop_front()), 32'(got));
    chk("rts_on", 32'h1, 32'(rts));
    wt(rts, 1'b0, 3000);
    chk("tail", 32'h1, 32'(n >= 100 * CMS && n <= 100 * CMS + DIV));
    apb(1, 8'h00, 32'h0000_00E0);
    apb(1, 8'h14, 32'h0000_0033);
    wt(stb, 1'b1, 20 * DIV);
    chk("tx_if", 32'h33, 32'(got));
    chk("rts_if", 32'h0, 32'(rts));
    apb(1, 8'h00, 32'h0000_0100);
    repeat (DIV) @(negedge clk_sys);
    chk("drv_md", 32'h0, 32'(de));
    for (int m = 0; m < 2; m++) begin
      apb(1, 8'h00, m ? 32'h0000_0002 : 32'h0000_0040);
      b = 8'($random(seed));
      exp_q.push_back(b);
      slave.send(b, m == 1);
      rd = 32'h0;
      for (int k = 0; k < 40 && rd[8] !== 1'b1; k++)
        apb(0, 8'h18, 32'h0);
      chk("rx", {23'h0, 1'b1, exp_q.pop_front()}, rd);
    end
    apb(0, 8'h1C, 32'h0);
    chk("perr", 32'h0, 32'(rd[4]));
    apb(1, 8'h00, 32'h0000_0240);
    slave.send(8'($random(seed)), 1'b0);
    repeat (8 * DIV) @(posedge clk_sys);
    b = 8'($random(seed));
    exp_q.push_back(b);
    slave.send(b, 1'b0);
    apb(0, 8'h18, 32'h0);
    chk("hold", 32'h0, 32'(rd[8]));
    repeat (40 * DIV) @(posedge clk_sys);
    apb(0, 8'h18, 32'h0);
    chk("disc", {23'h0, 1'b1, exp_q.pop_front()}, rd);
    apb(0, 8'h18, 32'h0);
    chk("one", 32'h0, 32'(rd[8]));
    apb(1, 8'h10, 32'h1);
    apb(1, 8'h14, 32'h0000_0155);
    wt(stb, 1'b1, 20 * DIV);
    chk("tx_last", 32'h55, 32'(got));
    repeat (DIV + 4 * CMS) @(posedge clk_sys);
    apb(0, 8'h1C, 32'h0);
    chk("rspto", 32'h1, 32'(rd[8]));
    wrap_up();
  end
endmodule // serial_port_rts_toggle_uart_test
